//--- sfs_pkg.sv
// sfs_pkg: opcodes, status field layout, phase lengths and timing for the
// serial flash sequencer. assumes a 10 MHz system clock.
package sfs_pkg;

  // opcodes
  localparam logic [7:0] OP_WSR  = 8'h01;
  localparam logic [7:0] OP_WDIS = 8'h04;
  localparam logic [7:0] OP_WEN  = 8'h06;
  localparam logic [7:0] OP_RSR1 = 8'h05;
  localparam logic [7:0] OP_RSR2 = 8'h35;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_FAST = 8'h0B;
  localparam logic [7:0] OP_DOUT = 8'h3B;
  localparam logic [7:0] OP_QOUT = 8'h6B;
  localparam logic [7:0] OP_DIO  = 8'hBB;
  localparam logic [7:0] OP_QIO  = 8'hEB;

  // status_protect_low holds bits 7..2, status_protect_high bits 14..8
  localparam logic [5:0] SR1_RST     = 6'h00;
  localparam logic [6:0] SR2_RST     = 7'h00;
  localparam int         SR2_COMPL     = 6;
  localparam int         SR2_QUAD_EN   = 1;
  localparam int         SR2_PROT_HI   = 0;
  localparam logic [6:0] SR2_LOCK_MASK = 7'h3C;

  // continuous read arm pattern on mode bits 5..4
  localparam logic [1:0] CONT_ARM = 2'h2;

  // phase lengths in bits or clocks
  localparam int OPC_BITS  = 8;
  localparam int ADDR_BITS = 24;
  localparam int MODE_BITS = 8;
  localparam int DUMMY_STD = 8;
  localparam int DUMMY_QIO = 4;
  localparam int WSR_SHORT = 8;
  localparam int WSR_LONG  = 16;

  // self-timed status write
  localparam int CLK_MHZ              = 10;
  localparam int STATUS_WRITE_TIME_US = 10;
  localparam int STATUS_WRITE_CYCLES  = STATUS_WRITE_TIME_US * CLK_MHZ;

  typedef enum logic [6:0] {
    ST_OPC   = 7'h01,
    ST_ADDR  = 7'h02,
    ST_MODE  = 7'h04,
    ST_DUMMY = 7'h08,
    ST_DATA  = 7'h10,
    ST_WSR   = 7'h20,
    ST_SKIP  = 7'h40
  } sfs_state_t;

endpackage : sfs_pkg

//--- sfs_sync.sv
// sfs_sync: two-stage synchroniser for a bundle of pins.
// assumes each bit is an independent level; no bus coherence.
`timescale 1ns/10ps
module sfs_sync #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input  logic         clk_sys,
  input  logic         arst_n,
  // pins in, synchronised out
  input  logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] metaQ;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      metaQ <= RST_VAL;
      q     <= RST_VAL;
    end else begin
      metaQ <= d;
      q     <= metaQ;
    end
  end

endmodule : sfs_sync

//--- sfs_array.sv
// sfs_array: byte array behind the read path, one write and one read port.
// assumes the read address settles well before the data is used.
`timescale 1ns/10ps
module sfs_array #(
  parameter int AW = 8
) (
  // clock
  input  logic          clk_sys,
  // preload port
  input  logic          wrEn,
  input  logic [AW-1:0] wrAddr,
  input  logic [7:0]    wrData,
  // read port, one cycle latency
  input  logic [AW-1:0] rdAddr,
  output logic [7:0]    rdData
);

  logic [7:0] mem [2**AW];

  always_ff @(posedge clk_sys) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end

endmodule : sfs_array

//--- sfs_flash_seq.sv
// sfs_flash_seq: serial flash command sequencer, status write and read family.
// assumes sck is slow against clk_sys (at least 4 system clocks per half period).
// Contract
// [RQ1] status write opcode accepted only while write enable latch is set
// [RQ2] status write changes only bits 7..2 and 14..8
// [RQ3] security lock bits once set can never be cleared
// [RQ4] status write executes only if chip select rises after 8 or 16 bits
// [RQ5] an eight-bit status write clears complement, quad enable and protect high bits
// [RQ6] valid status write starts a timed busy cycle; status reads still answered
// [RQ7] end of the busy cycle clears the write enable latch
// [RQ8] all status bits start at zero
// [RQ9] plain read takes opcode and 24-bit address on rising edges
// [RQ10] read data leaves on falling edges, most significant bit first
// [RQ11] address increments after each byte until chip select rises
// [RQ12] reads arriving while busy are ignored entirely
// [RQ13] fast read inserts eight dummy clocks; output undriven meanwhile
// [RQ14] dual output read is fast read with data on lines 0 and 1
// [RQ15] host releases line 0 before the first dual data clock
// [RQ16] quad output read uses four lines, needs quad enable set
// [RQ17] host floats shared lines before first data clock
// [RQ18] dual io read takes address and mode two bits per clock
// [RQ19] mode bits 5..4 equal 10 arm opcode-less next read
// [RQ20] any other mode value returns to normal opcode decoding
// [RQ21] lower four mode bits are ignored
// [RQ22] quad io read: four lines, four dummy clocks, needs quad enable
// [RQ23] dual bytes: line 1 carries odd bits, line 0 even bits
// [RQ24] quad bytes: lines 3..0 carry bits 7..4 then 3..0
// [RQ25] host drives odd address bits on line 1, even on line 0
// [RQ26] host drives quad address with line 3 carrying bit 23 first
// [RQ27] sixteen-bit write: first byte low register, second high register
`timescale 1ns/10ps
module sfs_flash_seq
  import sfs_pkg::*;
#(
  parameter int ARRAY_AW  = 8,
  parameter int WSR_TICKS = STATUS_WRITE_CYCLES
) (
  // system
  input  logic                clk_sys,
  input  logic                arst_n,
  // serial link pins
  input  logic                csN,
  input  logic                sck,
  input  logic [3:0]          dataLineIn,
  output logic [3:0]          dataLineOut,
  output logic [3:0]          dataLineOe,
  // array preload
  input  logic                arrWrEn,
  input  logic [ARRAY_AW-1:0] arrWrAddr,
  input  logic [7:0]          arrWrData,
  // status view, high byte then low byte
  output logic [15:0]         statusView
);

  logic [5:0]  pinS;
  logic        csHi;
  logic        sckS;
  logic [3:0]  ioS;
  logic        sckPrevQ;
  logic        csPrevQ;
  logic        riseEv;
  logic        fallEv;
  logic        csRise;

  sfs_state_t  stateQ, stateD;
  logic [1:0]  laneQ, laneD;
  logic [7:0]  cmdQ, cmdD;
  logic [4:0]  cntQ, cntD;
  logic [23:0] shQ, shD;
  logic [23:0] addrQ, addrD;
  logic [7:0]  modeQ, modeD;
  logic [7:0]  outShQ, outShD;
  logic [2:0]  chunkQ, chunkD;
  logic [4:0]  wsrCntQ, wsrCntD;
  logic [3:0]  ioOutQ, ioOutD;
  logic [3:0]  ioOeQ, ioOeD;
  logic        contQ, contD;
  logic [7:0]  contCmdQ, contCmdD;
  logic        wrEnLatchQ, wrEnLatchD;
  logic [5:0]  sr1Q, sr1D;
  logic [6:0]  sr2Q, sr2D;
  logic [15:0] busyCntQ, busyCntD;

  logic        busy;
  logic        quadEn;
  logic [23:0] shIn;
  logic [7:0]  opc;
  logic        opcDone;
  logic        opcRead;
  logic        opcQuad;
  sfs_state_t  opcNext;
  logic [1:0]  opcLane;
  logic [1:0]  dataLane;
  logic [4:0]  addrLast;
  logic [4:0]  modeLast;
  logic [4:0]  dumLast;
  logic [2:0]  chunkLast;
  logic [3:0]  stepBits;
  logic        statRd;
  logic        ioCmd;
  logic [7:0]  stat1;
  logic [7:0]  stat2;
  logic [7:0]  memData;
  logic [7:0]  srcByte;
  logic [7:0]  byteV;
  logic        commit;
  logic        longWr;
  logic [7:0]  wrLow;
  logic [6:0]  sr2Keep;
  logic        weSet;
  logic        weClr;
  logic        busyDone;

  sfs_sync #(
    .W       (6),
    .RST_VAL (6'h20)
  ) uPinSync (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .d       ({csN, sck, dataLineIn}),
    .q       (pinS)
  );

  sfs_array #(
    .AW (ARRAY_AW)
  ) uArray (
    .clk_sys (clk_sys),
    .wrEn    (arrWrEn),
    .wrAddr  (arrWrAddr),
    .wrData  (arrWrData),
    .rdAddr  (addrQ[ARRAY_AW-1:0]),
    .rdData  (memData)
  );

  assign csHi   = pinS[5];
  assign sckS   = pinS[4];
  assign ioS    = pinS[3:0];
  assign riseEv = !csHi && sckS && !sckPrevQ;
  assign fallEv = !csHi && !sckS && sckPrevQ;
  assign csRise = csHi && !csPrevQ;

  assign busy     = busyCntQ != 16'h0000;
  assign busyDone = busyCntQ == 16'h0001;
  assign quadEn   = sr2Q[SR2_QUAD_EN];

  // [RQ25] odd bits on line 1, even on line 0
  // [RQ26] line 3 holds the highest bit of each nibble
  assign shIn = (laneQ == 2'h2) ? {shQ[19:0], ioS} :
                (laneQ == 2'h1) ? {shQ[21:0], ioS[1:0]} : {shQ[22:0], ioS[0]};

  // [RQ9] opcode decode on rising edges
  assign opc     = shIn[7:0];
  assign opcDone = riseEv && (stateQ == ST_OPC) && (cntQ == 5'(OPC_BITS - 1));
  assign opcQuad = (opc == OP_QOUT) || (opc == OP_QIO);
  assign opcRead = (opc == OP_READ) || (opc == OP_FAST) || (opc == OP_DOUT) ||
                   (opc == OP_DIO) || opcQuad;
  assign opcLane = (opc == OP_QIO) ? 2'h2 : (opc == OP_DIO) ? 2'h1 : 2'h0;

  // [RQ1] write enable gate
  // [RQ12] busy blocks reads
  // [RQ16] quad enable gate
  always_comb begin
    opcNext = ST_SKIP;
    if (opc == OP_WSR) begin
      opcNext = (wrEnLatchQ && !busy) ? ST_WSR : ST_SKIP;
    end else if ((opc == OP_RSR1) || (opc == OP_RSR2)) begin
      opcNext = ST_DATA;
    end else if (opcRead) begin
      opcNext = (busy || (opcQuad && !quadEn)) ? ST_SKIP : ST_ADDR;
    end
  end

  assign ioCmd    = (cmdQ == OP_DIO) || (cmdQ == OP_QIO);
  assign statRd   = (cmdQ == OP_RSR1) || (cmdQ == OP_RSR2);
  // [RQ14] dual output lane
  assign dataLane = ((cmdQ == OP_QOUT) || (cmdQ == OP_QIO)) ? 2'h2 :
                    ((cmdQ == OP_DOUT) || (cmdQ == OP_DIO)) ? 2'h1 : 2'h0;
  assign addrLast = 5'((ADDR_BITS >> laneQ) - 1);
  assign modeLast = 5'((MODE_BITS >> laneQ) - 1);
  // [RQ13] eight dummies, [RQ22] four for quad io
  assign dumLast  = (cmdQ == OP_QIO) ? 5'(DUMMY_QIO - 1) : 5'(DUMMY_STD - 1);
  assign chunkLast = 3'((8 >> laneQ) - 1);
  assign stepBits  = (laneQ == 2'h2) ? 4'h4 : (laneQ == 2'h1) ? 4'h2 : 4'h1;

  // [RQ6] status stays readable while busy
  assign stat1   = {sr1Q, wrEnLatchQ, busy};
  assign stat2   = {1'b0, sr2Q};
  assign srcByte = statRd ? ((cmdQ == OP_RSR2) ? stat2 : stat1) : memData;
  assign byteV   = (chunkQ == 3'h0) ? srcByte : outShQ;

  always_comb begin
    stateD   = stateQ;
    laneD    = laneQ;
    cmdD     = cmdQ;
    cntD     = cntQ;
    shD      = shQ;
    addrD    = addrQ;
    modeD    = modeQ;
    outShD   = outShQ;
    chunkD   = chunkQ;
    wsrCntD  = wsrCntQ;
    ioOutD   = ioOutQ;
    ioOeD    = ioOeQ;
    if (csHi) begin
      // [RQ19] armed: next frame starts at the address
      // [RQ20] otherwise a full opcode is expected
      stateD  = contQ ? (busy ? ST_SKIP : ST_ADDR) : ST_OPC;
      cmdD    = contCmdQ;
      laneD   = !contQ ? 2'h0 : (contCmdQ == OP_QIO) ? 2'h2 : 2'h1;
      cntD    = 5'h00;
      chunkD  = 3'h0;
      wsrCntD = 5'h00;
      ioOeD   = 4'h0;
    end else if (riseEv) begin
      case (stateQ)
        ST_OPC: begin
          shD  = shIn;
          cntD = cntQ + 5'h01;
          if (opcDone) begin
            cmdD   = opc;
            cntD   = 5'h00;
            stateD = opcNext;
            laneD  = opcLane;
          end
        end
        ST_ADDR: begin
          shD  = shIn;
          cntD = cntQ + 5'h01;
          if (cntQ == addrLast) begin
            addrD = shIn;
            cntD  = 5'h00;
            if (ioCmd) begin
              stateD = ST_MODE;
            end else if (cmdQ == OP_READ) begin
              stateD = ST_DATA;
              laneD  = dataLane;
            end else begin
              stateD = ST_DUMMY;
            end
          end
        end
        // [RQ18] mode byte after the address
        ST_MODE: begin
          shD  = shIn;
          cntD = cntQ + 5'h01;
          if (cntQ == modeLast) begin
            modeD  = shIn[7:0];
            cntD   = 5'h00;
            stateD = (cmdQ == OP_QIO) ? ST_DUMMY : ST_DATA;
            laneD  = dataLane;
          end
        end
        ST_DUMMY: begin
          cntD = cntQ + 5'h01;
          if (cntQ == dumLast) begin
            stateD = ST_DATA;
            laneD  = dataLane;
          end
        end
        // [RQ27] bytes stream in msb first
        ST_WSR: begin
          shD = shIn;
          if (wsrCntQ != 5'h1F) begin
            wsrCntD = wsrCntQ + 5'h01;
          end
        end
        default: begin
        end
      endcase
    end else if (fallEv && (stateQ == ST_DATA)) begin
      // [RQ10] msb first on falling edges
      // [RQ23] dual split, [RQ24] quad split
      ioOutD = (laneQ == 2'h2) ? byteV[7:4] :
               (laneQ == 2'h1) ? {2'h0, byteV[7:6]} : {2'h0, byteV[7], 1'b0};
      ioOeD  = (laneQ == 2'h2) ? 4'hF : (laneQ == 2'h1) ? 4'h3 : 4'h2;
      outShD = byteV << stepBits;
      chunkD = (chunkQ == chunkLast) ? 3'h0 : chunkQ + 3'h1;
      // [RQ11] next byte address
      if ((chunkQ == chunkLast) && !statRd) begin
        addrD = addrQ + 24'h000001;
      end
    end
  end

  // [RQ4] only 8 or 16 data bits execute
  assign commit = csRise && (stateQ == ST_WSR) && wrEnLatchQ && !busy &&
                  ((wsrCntQ == 5'(WSR_SHORT)) || (wsrCntQ == 5'(WSR_LONG)));
  assign longWr = wsrCntQ == 5'(WSR_LONG);
  assign wrLow  = longWr ? shQ[15:8] : shQ[7:0];
  // [RQ3] lock bits only accumulate
  // [RQ5] short write drops complement, quad enable, protect high
  assign sr2Keep = sr2Q & SR2_LOCK_MASK;
  // [RQ2] only writable fields loaded
  assign sr1D = commit ? wrLow[7:2] : sr1Q;
  assign sr2D = !commit ? sr2Q : longWr ? (shQ[6:0] | sr2Keep) : sr2Keep;

  // [RQ6] self-timed busy cycle
  assign busyCntD = commit ? 16'(WSR_TICKS) : busy ? busyCntQ - 16'h0001 : 16'h0000;
  assign weSet    = opcDone && (opc == OP_WEN) && !busy;
  // [RQ7] latch drops at cycle end
  assign weClr    = (opcDone && (opc == OP_WDIS) && !busy) || busyDone;
  assign wrEnLatchD = weSet || (wrEnLatchQ && !weClr);

  // [RQ21] only mode bits 5..4 are looked at
  assign contD    = (csRise && ioCmd && ((stateQ == ST_DATA) || (stateQ == ST_DUMMY))) ?
                    (modeQ[5:4] == CONT_ARM) : contQ;
  assign contCmdD = csRise ? cmdQ : contCmdQ;

  assign dataLineOut = ioOutQ;
  assign dataLineOe  = ioOeQ;
  assign statusView  = {stat2, stat1};

  // [RQ8] factory state all zero
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sr1Q     <= SR1_RST;
      sr2Q     <= SR2_RST;
      wrEnLatchQ <= 1'b0;
      busyCntQ <= 16'h0000;
      contQ    <= 1'b0;
      contCmdQ <= 8'h00;
    end else begin
      sr1Q     <= sr1D;
      sr2Q     <= sr2D;
      wrEnLatchQ <= wrEnLatchD;
      busyCntQ <= busyCntD;
      contQ    <= contD;
      contCmdQ <= contCmdD;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sckPrevQ <= 1'b0;
      csPrevQ  <= 1'b1;
      stateQ   <= ST_OPC;
      laneQ    <= 2'h0;
      cmdQ     <= 8'h00;
      cntQ     <= 5'h00;
      shQ      <= 24'h000000;
      addrQ    <= 24'h000000;
      modeQ    <= 8'h00;
      outShQ   <= 8'h00;
      chunkQ   <= 3'h0;
      wsrCntQ  <= 5'h00;
      ioOutQ   <= 4'h0;
      ioOeQ    <= 4'h0;
    end else begin
      sckPrevQ <= sckS;
      csPrevQ  <= csHi;
      stateQ   <= stateD;
      laneQ    <= laneD;
      cmdQ     <= cmdD;
      cntQ     <= cntD;
      shQ      <= shD;
      addrQ    <= addrD;
      modeQ    <= modeD;
      outShQ   <= outShD;
      chunkQ   <= chunkD;
      wsrCntQ  <= wsrCntD;
      ioOutQ   <= ioOutD;
      ioOeQ    <= ioOeD;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);

  chk_wsr_enable_gate: assert property ( // [RQ1]
    (opcDone && (opc == OP_WSR) && !wrEnLatchQ) |=> (stateQ == ST_SKIP))
    else $error("status write taken without write enable");
  chk_lock_sticky: assert property ( // [RQ3]
    1'b1 |=> ((sr2Q & $past(sr2Q) & SR2_LOCK_MASK) == ($past(sr2Q) & SR2_LOCK_MASK)))
    else $error("security lock bit cleared");
  chk_wsr_bad_count: assert property ( // [RQ4]
    (csRise && (stateQ == ST_WSR) && !busy && (wsrCntQ != 5'h08) && (wsrCntQ != 5'h10))
    |=> (!busy && (sr1Q == $past(sr1Q)) && (sr2Q == $past(sr2Q))))
    else $error("status write with wrong bit count executed");
  chk_short_clear: assert property ( // [RQ5]
    (commit && !longWr) |=> (!sr2Q[SR2_COMPL] && !sr2Q[SR2_QUAD_EN] && !sr2Q[SR2_PROT_HI]))
    else $error("short status write kept complement, quad enable or protect high");
  chk_busy_cycle: assert property ( // [RQ6]
    commit |=> busy [*8])
    else $error("busy not held after status write");
  chk_latch_clear: assert property ( // [RQ7]
    $fell(busy) |-> !wrEnLatchQ)
    else $error("write enable latch still set after write cycle");
  chk_read_busy: assert property ( // [RQ12]
    (opcDone && busy && opcRead) |=> (stateQ == ST_SKIP))
    else $error("read accepted while busy");
  chk_quad_gate: assert property ( // [RQ16]
    (opcDone && opcQuad && !quadEn) |=> (stateQ == ST_SKIP))
    else $error("quad read accepted without quad enable");
  chk_addr_step: assert property ( // [RQ11]
    (fallEv && (stateQ == ST_DATA) && !statRd && (chunkQ == chunkLast))
    |=> (addrQ == $past(addrQ) + 24'h000001))
    else $error("read address did not advance after byte");
  chk_dual_split: assert property ( // [RQ23]
    (fallEv && (stateQ == ST_DATA) && (laneQ == 2'h1) && (chunkQ == 3'h0))
    |=> (ioOutQ[1:0] == $past(srcByte[7:6])))
    else $error("dual output bit order wrong");

endmodule : sfs_flash_seq

//--- sfs_host_model.sv
// sfs_host_model: host-side SPI controller that drives the sequencer pins.
// assumes clk_sys at 10 MHz; sck runs at 800 ns and moves just after clk_sys edges.
`timescale 1ns/10ps
module sfs_host_model (
  // system
  input  logic        clk_sys,
  // device drive of the data lines
  input  logic [3:0]  dataLineOut,
  input  logic [3:0]  dataLineOe,
  // host pins
  output logic        csN,
  output logic        sck,
  output logic [3:0]  dataLineIn
);
  logic [3:0]  hostVal = 4'h0;
  logic [3:0]  hostOe  = 4'h0;
  logic [3:0]  noise   = 4'h5;
  logic [3:0]  smp;
  logic [3:0]  smpOe;
  logic [11:0] rxRes;
  event        byteEv;

  initial begin
    csN = 1'b1;
    sck = 1'b0;
  end

  // floating lines toggle every cycle, so a stale level never reads as data
  always @(posedge clk_sys) noise <= ~noise;
  assign dataLineIn = (dataLineOe & dataLineOut) | (~dataLineOe & hostOe & hostVal)
                    | (~dataLineOe & ~hostOe & noise);

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : wait_clk

  // one sck period; the wire is sampled late in the high phase
  task automatic tick(input logic [3:0] v, input logic [3:0] oe);
    // an edge passes after the release, so release and drive never share a step
    wait_clk(1);
    hostVal = v;
    hostOe  = oe;
    wait_clk(3);
    sck = 1'b1;
    wait_clk(4);
    smp   = dataLineIn;
    smpOe = dataLineOe;
    hostOe = 4'h0;
    sck    = 1'b0;
  endtask : tick

  task automatic send(input logic [31:0] val, input int n, input int lanes);
    logic [31:0] v;
    v = val << (32 - n);
    for (int i = 0; i < n / lanes; i++) begin
      tick(v[31:28] >> (4 - lanes), 4'hF >> (4 - lanes));
      v = v << lanes;
    end
  endtask : send

  // nothing driven is reported as zero
  task automatic rd(input int lanes, input int nb);
    logic [7:0] acc;
    logic [3:0] oeOr;
    for (int b = 0; b < nb; b++) begin
      acc  = 8'h00;
      oeOr = 4'h0;
      for (int k = 0; k < 8 / lanes; k++) begin
        tick(4'h0, 4'h0);
        oeOr = oeOr | smpOe;
        acc  = (acc << lanes) | 8'(lanes == 1 ? {3'b000, smp[1]} : smp & (4'hF >> (4 - lanes)));
      end
      rxRes = (oeOr == 4'h0) ? 12'h000 : {oeOr, acc};
      -> byteEv;
    end
  endtask : rd

  task automatic cs_lo();
    csN = 1'b0;
    wait_clk(4);
  endtask : cs_lo

  task automatic cs_hi();
    wait_clk(4);
    csN = 1'b1;
    wait_clk(6);
  endtask : cs_hi
endmodule : sfs_host_model

//--- sfs_flash_seq_tb_top.sv
// sfs_flash_seq_tb_top: self-checking bench for the flash sequencer.
// assumes sfs_host_model as the host; results are checked against queued notes.
`timescale 1ns/10ps
module sfs_flash_seq_tb_top
  import sfs_pkg::*;
;
  localparam int WSR_T = 800;
  localparam int CEIL  = 40000;
  logic        clk_sys;
  logic        arst_n;
  logic        csN;
  logic        sck;
  logic [3:0]  dataLineIn;
  logic [3:0]  dataLineOut;
  logic [3:0]  dataLineOe;
  logic        arrWrEn;
  logic [7:0]  arrWrAddr;
  logic [7:0]  arrWrData;
  logic [15:0] statusView;
  logic [7:0]  mem [256];
  logic [15:0] expQ [$];
  logic [23:0] a;
  logic [7:0]  op;
  event        stEv;
  int          errors = 0;
  int          compares = 0;
  int          seed = 90;
  int          cycles = 0;
  int          busyN;
  int          ln;

  sfs_flash_seq #(.ARRAY_AW(8), .WSR_TICKS(WSR_T)) sfs_flash_seq_inst (
    .clk_sys(clk_sys), .arst_n(arst_n), .csN(csN), .sck(sck), .dataLineIn(dataLineIn),
    .dataLineOut(dataLineOut), .dataLineOe(dataLineOe), .arrWrEn(arrWrEn),
    .arrWrAddr(arrWrAddr), .arrWrData(arrWrData), .statusView(statusView));
  sfs_host_model host (.clk_sys(clk_sys), .dataLineOut(dataLineOut), .dataLineOe(dataLineOe),
    .csN(csN), .sck(sck), .dataLineIn(dataLineIn));

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic print_verdict();
    if (expQ.size() != 0) errors++;
    $display("counts: %0d compares, %0d errors", compares, errors);
    if (errors == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict

  always @(host.byteEv) check({4'h0, host.rxRes}, expQ.pop_front(), "link byte");
  always @(stEv) check(statusView, expQ.pop_front(), "status view");

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == CEIL) begin
      errors++;
      $display("mismatch at %0t: run too long", $time);
      print_verdict();
    end
  end

  task automatic peek(input logic [15:0] e);
    expQ.push_back(e);
    -> stEv;
    #0;
  endtask : peek

  task automatic rd_cmd(input logic [7:0] o, input bit withOp, input int al, input logic [23:0] ad,
                        input int ml, input logic [7:0] m, input int dum, input int dl,
                        input int nb, input bit ok);
    for (int i = 0; i < nb; i++)
      expQ.push_back(ok ? {4'h0, (dl == 1) ? 4'h2 : (dl == 2) ? 4'h3 : 4'hF, mem[8'(ad + 24'(i))]} : 16'h0);
    host.cs_lo();
    if (withOp) host.send(o, 8, 1);
    host.send(ad, 24, al);
    if (ml > 0) host.send(m, 8, ml);
    repeat (dum) host.tick(4'h0, 4'h0);
    host.rd(dl, nb);
    host.cs_hi();
  endtask : rd_cmd

  task automatic st_rd(input logic [7:0] o, input logic [7:0] e);
    expQ.push_back({8'h02, e});
    host.cs_lo();
    host.send(o, 8, 1);
    host.rd(1, 1);
    host.cs_hi();
  endtask : st_rd

  task automatic wsr(input logic [15:0] v, input int n, input bit we);
    if (we) begin
      host.cs_lo();
      host.send(OP_WEN, 8, 1);
      host.cs_hi();
    end
    host.cs_lo();
    host.send(OP_WSR, 8, 1);
    host.send(32'(v) >> (16 - n), n, 1);
    host.cs_hi();
  endtask : wsr

  task automatic wait_idle();
    busyN = 0;
    while (statusView[0] !== 1'b0) begin
      host.wait_clk(1);
      busyN++;
    end
  endtask : wait_idle

  initial begin
    arst_n    = 1'b0;
    arrWrEn   = 1'b0;
    arrWrAddr = 8'h00;
    arrWrData = 8'h00;
    repeat (2) @(posedge clk_sys);
    #1 arst_n = 1'b1;
    host.wait_clk(4);
    peek(16'h0000);
    for (int i = 0; i < 256; i++) begin
      mem[i]    = 8'($random(seed));
      arrWrEn   = 1'b1;
      arrWrAddr = 8'(i);
      arrWrData = mem[i];
      host.wait_clk(1);
    end
    arrWrEn = 1'b0;
    rd_cmd(OP_READ, 1, 1, 24'h0000FE, 0, 8'h00, 0, 1, 4, 1);
    rd_cmd(OP_FAST, 1, 1, 24'($random(seed)), 0, 8'h00, 8, 1, 2, 1);
    rd_cmd(OP_DOUT, 1, 1, 24'($random(seed)), 0, 8'h00, 8, 2, 2, 1);
    rd_cmd(OP_QOUT, 1, 1, 24'($random(seed)), 0, 8'h00, 8, 4, 1, 0);
    rd_cmd(OP_QIO, 1, 4, 24'($random(seed)), 4, 8'h00, 4, 4, 1, 0);
    $display("test basic reads done");
    wsr(16'hFFFF, 16, 0);
    peek(16'h0000);
    wsr(16'hFFC3, 16, 1);
    peek({1'b0, 7'h43, 6'h3F, 2'b11});
    st_rd(OP_RSR1, 8'hFF);
    st_rd(OP_RSR2, 8'h43);
    rd_cmd(OP_READ, 1, 1, 24'h000010, 0, 8'h00, 0, 1, 1, 0);
    wait_idle();
    peek({1'b0, 7'h43, 6'h3F, 2'b00});
    $display("test status write done");
    rd_cmd(OP_QOUT, 1, 1, 24'($random(seed)), 0, 8'h00, 8, 4, 2, 1);
    for (int j = 0; j < 2; j++) begin
      op = (j == 0) ? OP_DIO : OP_QIO;
      ln = (j == 0) ? 2 : 4;
      a  = 24'($random(seed));
      // quad io waits four dummy clocks after the mode byte, dual io none
      rd_cmd(op, 1, ln, a, ln, {4'h2, 4'($random(seed))}, 4 * j, ln, 2, 1);
      rd_cmd(op, 0, ln, a + 24'h5, ln, {4'hD, 4'($random(seed))}, 4 * j, ln, 1, 1);
      rd_cmd(OP_READ, 1, 1, a + 24'h9, 0, 8'h00, 0, 1, 1, 1);
    end
    $display("test io reads done");
    wsr(16'h00FF, 16, 1);
    wait_idle();
    peek({1'b0, 7'h7F, 6'h00, 2'b00});
    wsr(16'h0C00, 8, 1);
    wait_idle();
    check(16'(busyN >= WSR_T - 8 && busyN <= WSR_T), 16'h0001, "busy length");
    peek({1'b0, 7'h3C, 6'h03, 2'b00});
    wsr(16'h0000, 16, 1);
    wait_idle();
    peek({1'b0, 7'h3C, 6'h00, 2'b00});
    wsr(16'hFFFF, 12, 1);
    wait_idle();
    peek({1'b0, 7'h3C, 6'h00, 2'b10});
    // write disable drops the latch, so the following status write is refused
    host.cs_lo();
    host.send(OP_WDIS, 8, 1);
    host.cs_hi();
    wsr(16'hFFFF, 16, 0);
    peek({1'b0, 7'h3C, 6'h00, 2'b00});
    $display("test lock and length done");
    print_verdict();
  end
endmodule : sfs_flash_seq_tb_top
